// ===== pkt_pkg.sv
package pkt_pkg;
  // FIFO geometry: 64 entries, pointers carry one wrap bit.
  localparam int          FIFO_AW    = 6;
  localparam int          PTR_W      = 7;
  localparam logic [6:0]  FIFO_DEPTH = 7'h40;
  localparam int          SYNC_W     = 32;
  // Checksum variants.
  localparam logic [15:0] CCITT_POLY = 16'h1021;
  localparam logic [15:0] CCITT_SEED = 16'h1D0F;
  localparam logic [15:0] IBM_POLY   = 16'h8005;
  localparam logic [15:0] IBM_SEED   = 16'hFFFF;
  // Whitening generator seed.
  localparam logic [8:0]  WHITE_SEED = 9'h1FF;
  // Line coding and address filter selections.
  localparam logic [1:0]  DC_MANCH   = 2'h1;
  localparam logic [1:0]  DC_WHITE   = 2'h2;
  localparam logic [1:0]  ADDR_NODE  = 2'h1;
  localparam logic [1:0]  ADDR_BOTH  = 2'h2;
  // Sizes of the length field handling and end values of the bit and sync counters.
  localparam logic [11:0] LEN_OPEN   = 12'hFFF;
  localparam logic [11:0] CRC_BYTES  = 12'h002;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam logic [4:0]  LAST_SYNC  = 5'h1F;
  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_DATA = 1'b1
  } rx_state_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_DATA = 2'b10,
    TX_DONE = 2'b11
  } tx_state_type;
endpackage

// ===== packet_filter_crc_dc_free_mode.sv
`timescale 1ns/100ps
module packet_filter_crc_dc_free_mode (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Air side.
  input  wire logic        sym_tick_i,
  input  wire logic        rx_sym_i,
  output logic             tx_sym_o,
  output logic             tx_active_o,
  output logic             packet_sent_o,
  // Operating mode.
  input  wire logic        rx_mode_i,
  input  wire logic        tx_mode_i,
  // Configuration.
  input  wire logic [31:0] sync_value_i,
  input  wire logic        packet_format_i,
  input  wire logic [10:0] payload_length_d_i,
  input  wire logic [1:0]  address_filter_mode_i,
  input  wire logic [7:0]  node_address_b_i,
  input  wire logic [7:0]  broadcast_address_c_i,
  input  wire logic        crc_enable_i,
  input  wire logic        crc_autoclear_off_f_i,
  input  wire logic        crc_type_select_i,
  input  wire logic [1:0]  dc_free_mode_i,
  input  wire logic        beacon_enable_i,
  input  wire logic [5:0]  fifo_threshold_i,
  // Host FIFO port.
  input  wire logic        fifo_wr_i,
  input  wire logic [7:0]  fifo_wr_data_i,
  input  wire logic        fifo_rd_i,
  output logic [7:0]       fifo_rd_data_o,
  input  wire logic        fifo_overrun_clr_i,
  // Status.
  output logic             sync_address_match_a_o,
  output logic             crc_ok_e_o,
  output logic             payload_ready_g_o,
  output logic             fifo_empty_flag_o,
  output logic             fifo_full_flag_o,
  output logic             fifo_level_flag_o,
  output logic             fifo_overrun_h_o
);
  typedef struct packed {
    logic                rx_s1;
    logic                rx_s2;
    pkt_pkg::rx_state_type rx_state;
    logic [31:0]         rx_shift;
    logic                rx_half;
    logic                rx_first;
    logic [2:0]          rx_bits;
    logic [11:0]         rx_idx;
    logic [11:0]         rx_total;
    logic [15:0]         rx_crc;
    logic [8:0]          rx_lfsr;
    logic [6:0]          wp_start;
    pkt_pkg::tx_state_type tx_state;
    logic [31:0]         tx_shift;
    logic [4:0]          tx_bits;
    logic                tx_half;
    logic [11:0]         tx_left;
    logic [1:0]          tx_phase;
    logic [15:0]         tx_crc;
    logic [8:0]          tx_lfsr;
    logic                tx_sym;
    logic                tx_active;
    logic                packet_sent;
    logic                tx_mode_d;
    logic [6:0]          rd_save;
    logic [6:0]          wr;
    logic [6:0]          rd;
    logic [7:0]          rd_data;
    logic                empty;
    logic                full;
    logic                level;
    logic                overrun;
    logic                match;
    logic                crc_ok;
    logic                ready;
  } state_type;

  state_type   s;
  state_type   n;
  logic [7:0]  mem [0:63];
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rd;
  logic        manch;
  logic        white;
  logic        bit_in;
  logic        tx_raw;
  logic [7:0]  rbyte;
  logic        rx_push;
  logic        tx_pop;
  logic        flush;
  logic        len_bad;
  logic        addr_bad;
  logic        crc_fail;
  logic        crc_pass;
  logic        rx_end;
  logic [15:0] seed;
  logic [15:0] tx_final;
  logic [6:0]  cnt;

  // One checksum step on a single bit, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                           input logic t);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? (t ? pkt_pkg::IBM_POLY
                                                  : pkt_pkg::CCITT_POLY) : 16'h0000);
  endfunction

  // One step of the x^9 + x^5 + 1 whitening generator.
  function automatic logic [8:0] lfsr_step(input logic [8:0] l);
    lfsr_step = {l[0] ^ l[5], l[8:1]};
  endfunction

  assign mem_rd = mem[s.rd[pkt_pkg::FIFO_AW-1:0]];
  assign manch  = (dc_free_mode_i == pkt_pkg::DC_MANCH);
  assign white  = (dc_free_mode_i == pkt_pkg::DC_WHITE);
  assign seed   = crc_type_select_i ? pkt_pkg::IBM_SEED : pkt_pkg::CCITT_SEED;
  assign tx_raw = s.tx_shift[31];

  // Next-state logic for receiver, transmitter and FIFO.
  always_comb begin
    n         = s;
    mem_we    = 1'b0;
    mem_wdata = fifo_wr_data_i;
    bit_in    = 1'b0;
    rbyte     = 8'h00;
    rx_push   = 1'b0;
    tx_pop    = 1'b0;
    flush     = 1'b0;
    len_bad   = 1'b0;
    addr_bad  = 1'b0;
    crc_fail  = 1'b0;
    crc_pass  = 1'b0;
    rx_end    = 1'b0;
    tx_final  = 16'h0000;
    cnt       = 7'h00;
    n.rx_s1   = rx_sym_i;
    n.rx_s2   = s.rx_s1;
    n.packet_sent = 1'b0;
    n.tx_mode_d   = tx_mode_i;
    // Clears come first so that a set in the same cycle wins.
    if (s.empty) begin
      n.ready = 1'b0;
    end
    if (fifo_overrun_clr_i) begin
      n.overrun = 1'b0;
      flush     = 1'b1;
    end
    // Receiver.
    if (!rx_mode_i) begin
      n.rx_state = pkt_pkg::RX_HUNT;
      n.match    = 1'b0;
    end else if (sym_tick_i) begin
      unique case (s.rx_state)
        pkt_pkg::RX_HUNT: begin
          n.rx_shift = {s.rx_shift[30:0], s.rx_s2};
          if ({s.rx_shift[30:0], s.rx_s2} == sync_value_i) begin
            n.rx_state = pkt_pkg::RX_DATA;
            n.match    = 1'b1;
            n.crc_ok   = 1'b0;
            n.rx_idx   = 12'h000;
            n.rx_bits  = 3'h0;
            n.rx_half  = 1'b0;
            n.rx_total = packet_format_i ? pkt_pkg::LEN_OPEN : {1'b0, payload_length_d_i};
            n.rx_crc   = seed;
            n.rx_lfsr  = pkt_pkg::WHITE_SEED;
            n.wp_start = s.wr;
          end
        end
        pkt_pkg::RX_DATA: begin
          if (manch && !s.rx_half) begin
            n.rx_half  = 1'b1;
            n.rx_first = s.rx_s2;
          end else begin
            n.rx_half = 1'b0;
            // The first half of a Manchester pair carries the bit.
            bit_in = (manch ? s.rx_first : s.rx_s2) ^ (white & s.rx_lfsr[0]);
            if (white) begin
              n.rx_lfsr = lfsr_step(s.rx_lfsr);
            end
            n.rx_shift = {s.rx_shift[30:0], bit_in};
            if (s.rx_idx < s.rx_total) begin
              n.rx_crc = crc_step(s.rx_crc, bit_in, crc_type_select_i);
            end
            n.rx_bits = s.rx_bits + 3'h1;
            if (s.rx_bits == pkt_pkg::LAST_BIT) begin
              rbyte    = {s.rx_shift[6:0], bit_in};
              n.rx_idx = s.rx_idx + 12'h001;
              if (packet_format_i && s.rx_idx == 12'h000) begin
                len_bad    = ({3'h0, rbyte} >= payload_length_d_i);
                n.rx_total = {4'h0, rbyte} + 12'h001;
              end
              if (s.rx_idx == {11'h000, packet_format_i} &&
                  (address_filter_mode_i == pkt_pkg::ADDR_NODE ||
                   address_filter_mode_i == pkt_pkg::ADDR_BOTH)) begin
                addr_bad = (rbyte != node_address_b_i) &&
                           !(address_filter_mode_i == pkt_pkg::ADDR_BOTH &&
                             rbyte == broadcast_address_c_i);
              end
              if (len_bad || addr_bad) begin
                n.rx_state = pkt_pkg::RX_HUNT;
                n.match    = 1'b0;
              end else begin
                rx_push = (s.rx_idx < s.rx_total);
                rx_end  = (n.rx_idx == n.rx_total + (crc_enable_i ? pkt_pkg::CRC_BYTES
                                                                  : 12'h000));
              end
              if (rx_end) begin
                n.rx_state = pkt_pkg::RX_HUNT;
                crc_pass   = (n.rx_shift[15:0] ==
                              (crc_type_select_i ? s.rx_crc : ~s.rx_crc));
                crc_fail   = crc_enable_i && !crc_pass;
                n.crc_ok   = crc_enable_i && crc_pass;
                if (!crc_fail || crc_autoclear_off_f_i) begin
                  n.ready = 1'b1;
                end else begin
                  flush = 1'b1;
                end
              end
            end
          end
        end
      endcase
    end
    // Transmitter.
    if (!tx_mode_i) begin
      n.tx_state  = pkt_pkg::TX_IDLE;
      n.tx_active = 1'b0;
      n.tx_sym    = 1'b0;
    end else if (sym_tick_i) begin
      unique case (s.tx_state)
        pkt_pkg::TX_IDLE: begin
          if (!s.empty) begin
            n.tx_state  = pkt_pkg::TX_SYNC;
            n.tx_shift  = sync_value_i;
            n.tx_bits   = 5'h00;
            n.tx_active = 1'b1;
          end
        end
        pkt_pkg::TX_SYNC: begin
          n.tx_sym   = tx_raw;
          n.tx_shift = {s.tx_shift[30:0], 1'b0};
          n.tx_bits  = s.tx_bits + 5'h01;
          if (s.tx_bits == pkt_pkg::LAST_SYNC) begin
            tx_pop     = 1'b1;
            n.tx_state = pkt_pkg::TX_DATA;
            n.tx_shift = {mem_rd, 24'h000000};
            n.tx_left  = packet_format_i ? {4'h0, mem_rd}
                                         : {1'b0, payload_length_d_i} - 12'h001;
            n.tx_bits  = 5'h00;
            n.tx_half  = 1'b0;
            n.tx_phase = 2'h0;
            n.tx_crc   = seed;
            n.tx_lfsr  = pkt_pkg::WHITE_SEED;
          end
        end
        pkt_pkg::TX_DATA: begin
          if (manch && s.tx_half) begin
            n.tx_sym  = ~s.tx_sym;
            n.tx_half = 1'b0;
          end else begin
            n.tx_sym  = tx_raw ^ (white & s.tx_lfsr[0]);
            n.tx_half = manch;
            if (white) begin
              n.tx_lfsr = lfsr_step(s.tx_lfsr);
            end
            if (s.tx_phase == 2'h0) begin
              n.tx_crc = crc_step(s.tx_crc, tx_raw, crc_type_select_i);
            end
          end
          if (!(manch && !s.tx_half)) begin
            n.tx_shift = {s.tx_shift[30:0], 1'b0};
            n.tx_bits  = s.tx_bits + 5'h01;
            tx_final   = crc_type_select_i ? n.tx_crc : ~n.tx_crc;
            if (s.tx_bits[2:0] == pkt_pkg::LAST_BIT) begin
              n.tx_bits = 5'h00;
              if (s.tx_phase == 2'h0 && s.tx_left != 12'h000) begin
                tx_pop     = 1'b1;
                n.tx_shift = {mem_rd, 24'h000000};
                n.tx_left  = s.tx_left - 12'h001;
              end else if (crc_enable_i && s.tx_phase != 2'h2) begin
                n.tx_shift = {(s.tx_phase == 2'h0) ? tx_final[15:8] : tx_final[7:0],
                              24'h000000};
                n.tx_phase = s.tx_phase + 2'h1;
              end else begin
                n.tx_state    = pkt_pkg::TX_DONE;
                n.tx_active   = 1'b0;
                n.packet_sent = 1'b1;
              end
            end
          end
        end
        pkt_pkg::TX_DONE: begin
          n.tx_sym = 1'b0;
        end
      endcase
    end
    // FIFO write side: the receiver has priority over the host.
    if (rx_push || (fifo_wr_i && !tx_mode_i)) begin
      if (s.full) begin
        n.overrun = 1'b1;
      end else begin
        mem_we    = 1'b1;
        mem_wdata = rx_push ? rbyte : fifo_wr_data_i;
        n.wr      = s.wr + 7'h01;
      end
    end
    if (len_bad || addr_bad) begin
      n.wr = s.wp_start;
    end
    // FIFO read side: the transmitter has priority over the host.
    if (tx_pop) begin
      n.rd = s.rd + 7'h01;
    end else if (fifo_rd_i && !s.empty) begin
      n.rd_data = mem_rd;
      n.rd      = s.rd + 7'h01;
    end
    if (tx_mode_i && !s.tx_mode_d) begin
      n.rd_save = s.rd;
    end
    if (!tx_mode_i && s.tx_mode_d && beacon_enable_i) begin
      n.rd = s.rd_save;
    end
    if (flush) begin
      n.rd = n.wr;
    end
    // Flags follow the new pointers so they are registered outputs.
    cnt     = n.wr - n.rd;
    n.empty = (cnt == 7'h00);
    n.full  = (cnt == pkt_pkg::FIFO_DEPTH);
    n.level = (cnt > {1'b0, fifo_threshold_i});
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s          <= '0;
      s.rx_lfsr  <= pkt_pkg::WHITE_SEED;
      s.tx_lfsr  <= pkt_pkg::WHITE_SEED;
      s.empty    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // FIFO storage.
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[s.wr[pkt_pkg::FIFO_AW-1:0]] <= mem_wdata;
    end
  end

  assign tx_sym_o               = s.tx_sym;
  assign tx_active_o            = s.tx_active;
  assign packet_sent_o          = s.packet_sent;
  assign fifo_rd_data_o         = s.rd_data;
  assign sync_address_match_a_o = s.match;
  assign crc_ok_e_o             = s.crc_ok;
  assign payload_ready_g_o      = s.ready;
  assign fifo_empty_flag_o      = s.empty;
  assign fifo_full_flag_o       = s.full;
  assign fifo_level_flag_o      = s.level;
  assign fifo_overrun_h_o       = s.overrun;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence crc_bad_seq;
    crc_fail && !crc_autoclear_off_f_i;
  endsequence

  chk_sync_sets_flag: assert property (
    rx_mode_i && sym_tick_i && s.rx_state == pkt_pkg::RX_HUNT &&
    {s.rx_shift[30:0], s.rx_s2} == sync_value_i |=> s.match && s.rx_state == pkt_pkg::RX_DATA)
    else $error("sync match did not start payload");
  chk_ready_after_data: assert property (
    $rose(s.ready) |-> $past(s.rx_state) == pkt_pkg::RX_DATA)
    else $error("payload ready without a synced packet");
  chk_addr_discard: assert property (
    addr_bad |=> s.rx_state == pkt_pkg::RX_HUNT && s.wr == $past(s.wp_start) && !s.match)
    else $error("address mismatch not discarded");
  chk_len_discard: assert property (
    len_bad |=> s.rx_state == pkt_pkg::RX_HUNT && !s.ready)
    else $error("length limit not enforced");
  chk_crc_flush: assert property (
    crc_bad_seq |=> s.empty && !$rose(s.ready))
    else $error("failed checksum left data or raised ready");
  chk_crc_no_push: assert property (
    rx_end && crc_enable_i |-> !rx_push)
    else $error("checksum byte written to the fifo");
  chk_manch_pair: assert property (
    tx_mode_i && sym_tick_i && manch && s.tx_half && s.tx_state == pkt_pkg::TX_DATA
    |=> s.tx_sym == !$past(s.tx_sym))
    else $error("manchester half not inverted");
  chk_sync_nrz: assert property (
    tx_mode_i && sym_tick_i && s.tx_state == pkt_pkg::TX_SYNC
    |=> s.tx_sym == $past(s.tx_shift[31]))
    else $error("sync symbol altered");
  chk_beacon_back: assert property (
    !tx_mode_i && s.tx_mode_d && beacon_enable_i && !flush |=> s.rd == $past(s.rd_save))
    else $error("beacon fifo not restored");
  chk_white_seed: assert property (
    s.tx_state == pkt_pkg::TX_SYNC && n.tx_state == pkt_pkg::TX_DATA
    |=> s.tx_lfsr == pkt_pkg::WHITE_SEED)
    else $error("whitening not reseeded");
endmodule

// ===== remote_node.sv
`timescale 1ns/100ps
module remote_node (
  // Clock and symbol strobe.
  input  wire logic core_clk_i,
  input  wire logic sym_tick_i,
  // Air side.
  input  wire logic tx_sym_i,
  output logic      rx_sym_o
);
  logic seen_q[$];
  logic capture = 1'h0;
  initial rx_sym_o = 1'h0;
  // Records each transmitted symbol at a tick while capture is on.
  always @(posedge core_clk_i) begin
    if (capture && sym_tick_i) begin
      seen_q.push_back(tx_sym_i);
    end
  end
  // Turns sync and bytes into air symbols; whitening restarts with each payload.
  function automatic void encode(input logic [31:0] sw, input logic [7:0] d[$],
                                 input logic [1:0] dc, output logic s[$]);
    logic [8:0] l;
    logic       b;
    l = pkt_pkg::WHITE_SEED;
    for (int i = 31; i >= 0; i--) begin
      s.push_back(sw[i]);
    end
    foreach (d[k]) begin
      for (int j = 7; j >= 0; j--) begin
        b = d[k][j];
        if (dc == pkt_pkg::DC_WHITE) begin
          b = b ^ l[0];
          l = {l[0] ^ l[5], l[8:1]};
        end
        s.push_back(b);
        if (dc == pkt_pkg::DC_MANCH) begin
          s.push_back(~b);
        end
      end
    end
  endfunction
  // Sends a frame one symbol per tick, then parks the line at the inverse level.
  task automatic send(input logic [31:0] sw, input logic [7:0] d[$], input logic [1:0] dc);
    logic s[$];
    encode(sw, d, dc, s);
    s.push_back(~s[s.size()-1]);
    foreach (s[k]) begin
      @(posedge core_clk_i iff sym_tick_i);
      #1 rx_sym_o = s[k];
    end
  endtask
endmodule

// ===== packet_filter_crc_dc_free_mode_bench.sv
`timescale 1ns/100ps
module packet_filter_crc_dc_free_mode_bench;
  logic        core_clk_i, resetn_i, sym_tick_i, rx_sym_i, tx_sym_o, tx_active_o;
  logic        packet_sent_o, rx_mode_i, tx_mode_i, packet_format_i, crc_enable_i;
  logic        crc_autoclear_off_f_i, crc_type_select_i, beacon_enable_i, saw_match;
  logic [31:0] sync_value_i;
  logic [10:0] payload_length_d_i;
  logic [1:0]  address_filter_mode_i, dc_free_mode_i;
  logic [7:0]  node_address_b_i, broadcast_address_c_i, fifo_wr_data_i, fifo_rd_data_o;
  logic        fifo_wr_i, fifo_rd_i, fifo_overrun_clr_i, sync_address_match_a_o, crc_ok_e_o;
  logic        payload_ready_g_o, fifo_empty_flag_o, fifo_full_flag_o, fifo_level_flag_o;
  logic        fifo_overrun_h_o;
  int          fail_count = 0;
  int          comparisons = 0;
  packet_filter_crc_dc_free_mode DUT (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .sym_tick_i(sym_tick_i),
    .rx_sym_i(rx_sym_i), .tx_sym_o(tx_sym_o), .tx_active_o(tx_active_o),
    .packet_sent_o(packet_sent_o), .rx_mode_i(rx_mode_i), .tx_mode_i(tx_mode_i),
    .sync_value_i(sync_value_i), .packet_format_i(packet_format_i),
    .payload_length_d_i(payload_length_d_i), .address_filter_mode_i(address_filter_mode_i),
    .node_address_b_i(node_address_b_i), .broadcast_address_c_i(broadcast_address_c_i),
    .crc_enable_i(crc_enable_i), .crc_autoclear_off_f_i(crc_autoclear_off_f_i),
    .crc_type_select_i(crc_type_select_i), .dc_free_mode_i(dc_free_mode_i),
    .beacon_enable_i(beacon_enable_i), .fifo_threshold_i(6'h10), .fifo_wr_i(fifo_wr_i),
    .fifo_wr_data_i(fifo_wr_data_i), .fifo_rd_i(fifo_rd_i), .fifo_rd_data_o(fifo_rd_data_o),
    .fifo_overrun_clr_i(fifo_overrun_clr_i), .sync_address_match_a_o(sync_address_match_a_o),
    .crc_ok_e_o(crc_ok_e_o), .payload_ready_g_o(payload_ready_g_o),
    .fifo_empty_flag_o(fifo_empty_flag_o), .fifo_full_flag_o(fifo_full_flag_o),
    .fifo_level_flag_o(fifo_level_flag_o), .fifo_overrun_h_o(fifo_overrun_h_o));
  remote_node peer (.core_clk_i(core_clk_i), .sym_tick_i(sym_tick_i), .tx_sym_i(tx_sym_o),
                    .rx_sym_o(rx_sym_i));
  // Clock, symbol strobe every fourth cycle, and a note of any match seen.
  initial begin
    core_clk_i = 1'h0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    sym_tick_i = 1'h0;
    forever begin
      repeat (3) @(posedge core_clk_i);
      #1 sym_tick_i = 1'h1;
      @(posedge core_clk_i);
      #1 sym_tick_i = 1'h0;
    end
  end
  always @(posedge core_clk_i) if (sync_address_match_a_o === 1'h1) saw_match <= 1'h1;
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    #(95000 * 8);
    fail_count++;
    final_report();
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] d[$], input logic typ);
    logic [15:0] c;
    c = typ ? pkt_pkg::IBM_SEED : pkt_pkg::CCITT_SEED;
    foreach (d[k]) for (int j = 7; j >= 0; j--) begin
      c = {c[14:0], 1'h0} ^ ((c[15] ^ d[k][j]) ? (typ ? 16'h8005 : 16'h1021) : 16'h0000);
    end
    return typ ? c : ~c;
  endfunction
  function automatic void rnd(input int n, output logic [7:0] d[$]);
    repeat (n) d.push_back(8'($urandom_range(0, 255)));
  endfunction
  // Host FIFO writes back to back, reads with a compare per byte, and flush.
  task automatic wr_bytes(input logic [7:0] d[$]);
    fifo_wr_i = 1'h1;
    foreach (d[k]) begin
      fifo_wr_data_i = d[k];
      cyc(1);
    end
    fifo_wr_i = 1'h0;
    cyc(1);
  endtask
  task automatic rd_check(input logic [7:0] d[$]);
    fifo_rd_i = 1'h1;
    foreach (d[k]) begin
      cyc(1);
      check(fifo_rd_data_o, d[k]);
    end
    fifo_rd_i = 1'h0;
    cyc(1);
  endtask
  task automatic flush();
    fifo_overrun_clr_i = 1'h1;
    cyc(1);
    fifo_overrun_clr_i = 1'h0;
    cyc(2);
    check({fifo_empty_flag_o, fifo_overrun_h_o}, 2'h2);
  endtask
  // One line coding at a time, checksum on, no filtering.
  task automatic cfg(input logic [1:0] dc, input logic typ);
    dc_free_mode_i = dc;
    crc_type_select_i = typ;
    {crc_enable_i, crc_autoclear_off_f_i, packet_format_i} = 3'h4;
    address_filter_mode_i = 2'h0;
  endtask
  // Remote node sends one packet; expectations follow from the filter settings.
  task automatic rx_case(input logic good, input logic bad, input int n, input logic [7:0] a0);
    logic [7:0]  p[$];
    logic [7:0]  f[$];
    logic [15:0] c;
    logic        acc;
    logic        keep;
    rnd(n, p);
    if (packet_format_i) begin
      p[0] = 8'(n - 1);
      p[1] = a0;
    end else begin
      p[0] = a0;
      payload_length_d_i = 11'(n);
    end
    acc = good && (!packet_format_i || (n - 1) < payload_length_d_i)
      && (address_filter_mode_i == 2'h0 || a0 == node_address_b_i
      || (address_filter_mode_i == 2'h2 && a0 == broadcast_address_c_i));
    keep = acc && (!crc_enable_i || !bad || crc_autoclear_off_f_i);
    c = crc16(p, crc_type_select_i) ^ {15'h0000, bad};
    f = p;
    if (crc_enable_i) f = {f, c[15:8], c[7:0]};
    rx_mode_i = 1'h1;
    saw_match = 1'h0;
    peer.send(good ? sync_value_i : sync_value_i ^ 32'h00010000, f, dc_free_mode_i);
    cyc(8);
    check(saw_match, good);
    if (!bad) check(sync_address_match_a_o, acc);
    if (acc && crc_enable_i) check(crc_ok_e_o, !bad);
    check({payload_ready_g_o, fifo_empty_flag_o}, {keep, !keep});
    if (keep) rd_check(p);
    check(payload_ready_g_o, 1'h0);
    rx_mode_i = 1'h0;
    cyc(2);
  endtask
  // Host fills the FIFO once; the captured air stream is searched for the whole frame.
  task automatic tx_case(input int n, input logic bcn);
    logic [7:0] p[$];
    logic [7:0] f[$];
    logic [15:0] c;
    logic       e[$];
    logic       ok;
    int         w;
    rnd(n, p);
    packet_format_i = packet_format_i && !bcn;
    if (packet_format_i) p[0] = 8'(n - 1);
    p[packet_format_i] = node_address_b_i;
    payload_length_d_i = 11'(n);
    beacon_enable_i = bcn;
    wr_bytes(p);
    c = crc16(p, crc_type_select_i);
    f = p;
    if (crc_enable_i) f = {f, c[15:8], c[7:0]};
    peer.encode(sync_value_i, f, dc_free_mode_i, e);
    for (int r = 0; r <= int'(bcn); r++) begin
      peer.seen_q.delete();
      peer.capture = 1'h1;
      tx_mode_i = 1'h1;
      w = 0;
      while (packet_sent_o !== 1'h1 && w < 5000) begin
        cyc(1);
        w++;
      end
      check(w < 5000, 1'h1);
      cyc(8);
      check(tx_active_o, 1'h0);
      peer.capture = 1'h0;
      ok = 1'h0;
      for (int s = 0; s + e.size() <= peer.seen_q.size() && !ok; s++) begin
        ok = 1'h1;
        foreach (e[k]) if (peer.seen_q[s + k] !== e[k]) ok = 1'h0;
      end
      check(ok, 1'h1);
      tx_mode_i = 1'h0;
      cyc(3);
      check(fifo_empty_flag_o, !bcn);
    end
    beacon_enable_i = 1'h0;
    flush();
  endtask
  initial begin
    logic [7:0] q[$];
    void'($urandom(32'hBFCB));
    {resetn_i, rx_mode_i, tx_mode_i, fifo_wr_i, fifo_rd_i, fifo_overrun_clr_i} = 6'h00;
    {beacon_enable_i, fifo_wr_data_i, saw_match, payload_length_d_i} = 21'h000000;
    cfg(2'h0, 1'h0);
    for (int k = 0; k < 4; k++) sync_value_i[8*k +: 8] = 8'($urandom_range(1, 255));
    node_address_b_i = 8'($urandom_range(0, 127));
    broadcast_address_c_i = 8'($urandom_range(128, 255));
    repeat (20) @(posedge core_clk_i);
    #1 resetn_i = 1'h1;
    cyc(1);
    check({tx_sym_o, tx_active_o, packet_sent_o, sync_address_match_a_o, crc_ok_e_o,
           payload_ready_g_o, fifo_empty_flag_o, fifo_full_flag_o, fifo_level_flag_o,
           fifo_overrun_h_o, fifo_rd_data_o}, 18'h00800);
    rnd(64, q);
    wr_bytes(q);
    check({fifo_full_flag_o, fifo_level_flag_o}, 2'h3);
    wr_bytes(q[0:0]);
    check(fifo_overrun_h_o, 1'h1);
    flush();
    for (int m = 0; m < 6; m++) begin
      cfg(2'(m % 3), 1'(m / 3));
      packet_format_i = 1'(m % 2);
      tx_case(3 + m, 1'h0);
      rx_case(1'h1, 1'h0, 3 + m, node_address_b_i);
      rx_case(1'h1, 1'h1, 4, node_address_b_i);
    end
    crc_autoclear_off_f_i = 1'h1;
    rx_case(1'h1, 1'h1, 5, node_address_b_i);
    crc_enable_i = 1'h0;
    rx_case(1'h1, 1'h0, 3, node_address_b_i);
    tx_case(4, 1'h1);
    cfg(2'h0, 1'h0);
    rx_case(1'h0, 1'h0, 4, node_address_b_i);
    for (int m = 0; m < 9; m++) begin
      address_filter_mode_i = 2'(m / 3);
      rx_case(1'h1, 1'h0, 4, (m % 3 == 0) ? node_address_b_i : (m % 3 == 1) ?
              broadcast_address_c_i : node_address_b_i ^ 8'h01);
    end
    cfg(2'h0, 1'h0);
    packet_format_i = 1'h1;
    for (int m = 0; m < 3; m++) begin
      payload_length_d_i = (m == 2) ? 11'h7FF : 11'(4 + m);
      rx_case(1'h1, 1'h0, 5, node_address_b_i);
    end
    for (int m = 0; m < 8; m++) begin
      cfg(2'($urandom_range(0, 2)), 1'($urandom_range(0, 1)));
      {packet_format_i, crc_autoclear_off_f_i} = 2'($urandom_range(0, 3));
      address_filter_mode_i = 2'($urandom_range(0, 2));
      payload_length_d_i = 11'($urandom_range(2, 7));
      rx_case(1'h1, 1'($urandom_range(0, 1)), $urandom_range(2, 7),
              $urandom_range(0, 1) ? node_address_b_i : broadcast_address_c_i);
    end
    final_report();
  end
endmodule
